// ===== core/pps_status_flags.sv
// Fault, charge event and handshake outcome status flags with host pins
`include "pps_params.svh"

module pps_status_flags (
    input  wire logic            clk,
    input  wire logic            reset_n,
    // Host register port
    input  wire logic            reg_rd,
    input  wire logic            reg_wr,
    input  wire pps_pkg::pps_byte_t reg_addr,
    input  wire pps_pkg::pps_byte_t reg_wdata,
    output logic [7:0]           reg_rdata,
    // Comparator and engine inputs
    input  wire logic            supply_overvoltage,
    input  wire logic            bus_backvoltage,
    input  wire logic            bus_over_limit,
    input  wire logic            bus_over_r2min,
    input  wire logic            supply_uvlo,
    input  wire logic            thermal_reg_active,
    input  wire logic            light_load,
    input  wire logic            quota_reached,
    input  wire logic            attach_event,
    input  wire logic            removal_event,
    input  wire pps_pkg::pps_hs_e hs_result,
    input  wire logic            dedicated_charger_cycle,
    input  wire logic            new_profile_applied,
    input  wire logic            new_active_mode,
    input  wire logic            mode_select_line_one,
    input  wire logic            custom_dataswitch_close,
    input  wire logic            custom_const_current,
    // Configuration inputs
    input  wire logic            port_power_enable,
    input  wire logic            auto_recovery,
    input  wire logic            alert_link,
    input  wire logic            quota_enable,
    input  wire logic            quota_restart,
    input  wire pps_pkg::pps_action_t quota_action_sel,
    input  wire logic            dedicated_mode_dataswitch_ctrl,
    // Outputs
    output logic                 host_alert_n,
    output logic                 plug_detect_n,
    output logic                 power_switch_on,
    output logic                 data_switch_closed,
    output logic                 const_current_mode
);
    import pps_pkg::*;

    pps_byte_t fault_event_status, next_fault_event_status;
    pps_byte_t charge_event_status, next_charge_event_status;
    pps_byte_t handshake_outcome_status, next_handshake_outcome_status;
    logic      pt_armed, next_pt_armed;
    logic      mode_line_q, next_mode_line_q;
    logic      port_power_enable_q, next_port_power_enable_q;
    pps_byte_t next_reg_rdata;
    logic      next_host_alert_n, next_plug_detect_n, next_power_switch_on;
    logic      next_data_switch_closed, next_const_current_mode;

    function automatic logic hit(input pps_byte_t a, input pps_byte_t b);
        hit = (a == b);
    endfunction

    ////////////////////////////////////////////////////////////////////
    logic rd_fault, rd_charge, wr_fault, pwr_dis;
    logic c_ov, c_bv, c_oc, fault_clr, any_fault, fault_new, hs_clear;
    logic thermal_irq, light_irq, quota_irq;

    always_comb begin
        rd_fault  = reg_rd && hit(reg_addr, `PPS_ADDR_FAULT);
        rd_charge = reg_rd && hit(reg_addr, `PPS_ADDR_CHARGE);
        wr_fault  = reg_wr && hit(reg_addr, `PPS_ADDR_FAULT);
        pwr_dis   = port_power_enable_q && !port_power_enable;
        c_ov      = supply_overvoltage;
        c_bv      = bus_backvoltage;
        c_oc      = bus_over_limit && bus_over_r2min;
        next_fault_event_status = fault_event_status;
        next_charge_event_status = charge_event_status;
        next_handshake_outcome_status = handshake_outcome_status;
        next_pt_armed = pt_armed;
        next_mode_line_q = mode_select_line_one;
        next_port_power_enable_q = port_power_enable;

        // Fault flags: read clears only if the cause is gone; set wins
        if (rd_fault) begin
            if (!c_ov) next_fault_event_status[`PPS_FE_OVERVOLT] = 1'b0;
            if (!c_bv) next_fault_event_status[`PPS_FE_BACKV] = 1'b0;
            if (!c_oc) next_fault_event_status[`PPS_FE_OVERCUR] = 1'b0;
        end
        fault_clr = pwr_dis || (wr_fault && !reg_wdata[`PPS_FE_FAULT_STATE])
                    || (auto_recovery && !c_ov && !c_bv && !c_oc);
        any_fault = (|fault_event_status[2:0]) || c_ov || c_bv || c_oc;
        if (fault_clr && !(c_ov || c_bv || c_oc)) begin
            next_fault_event_status[2:0] = 3'b000;
        end
        if (c_ov) next_fault_event_status[`PPS_FE_OVERVOLT] = 1'b1;
        if (c_bv) next_fault_event_status[`PPS_FE_BACKV] = 1'b1;
        if (c_oc) next_fault_event_status[`PPS_FE_OVERCUR] = 1'b1;
        fault_new = c_ov || c_bv || c_oc;
        // Leaving the fault state needs a clear request with no fault cause active
        if (fault_new || (fault_event_status[`PPS_FE_FAULT_STATE] && any_fault
                          && !(fault_clr && !fault_new))) begin
            next_fault_event_status[`PPS_FE_FAULT_STATE] = 1'b1;
        end else if (fault_clr) begin
            next_fault_event_status[`PPS_FE_FAULT_STATE] = 1'b0;
        end

        // Charge events: read clears, event in same cycle wins
        if (rd_charge) begin
            next_charge_event_status[`PPS_CE_QUOTA]   = 1'b0;
            next_charge_event_status[`PPS_CE_THERMAL] = 1'b0;
            next_charge_event_status[`PPS_CE_LIGHT]   = 1'b0;
            next_charge_event_status[`PPS_CE_UNPLUG]  = 1'b0;
            next_charge_event_status[`PPS_CE_CONNECT] = 1'b0;
        end
        if (quota_restart || !quota_enable) begin
            next_charge_event_status[`PPS_CE_QUOTA] = 1'b0;
        end
        if (quota_reached && quota_enable) next_charge_event_status[`PPS_CE_QUOTA] = 1'b1;
        next_charge_event_status[`PPS_CE_REGION2] = bus_over_limit;
        if (thermal_reg_active) next_charge_event_status[`PPS_CE_THERMAL] = 1'b1;
        if (light_load) next_charge_event_status[`PPS_CE_LIGHT] = 1'b1;
        if (removal_event) next_charge_event_status[`PPS_CE_UNPLUG] = 1'b1;
        if (attach_event) next_charge_event_status[`PPS_CE_CONNECT] = 1'b1;
        next_charge_event_status[6:5] = 2'b00;

        // Handshake outcome flags
        hs_clear = pwr_dis || new_active_mode || removal_event;
        if (hs_clear) next_handshake_outcome_status[3:0] = 4'h0;
        if (new_profile_applied) begin
            next_handshake_outcome_status[`PPS_HS_NONEG] = 1'b0;
        end
        if (mode_select_line_one != mode_line_q) next_pt_armed = 1'b1;
        unique case (hs_result)
            PPS_HS_NOHANDSHAKE: begin
                if (dedicated_charger_cycle) begin
                    next_handshake_outcome_status = 8'h00;
                    next_handshake_outcome_status[`PPS_HS_NONEG] = 1'b1;
                end
            end
            PPS_HS_CUSTOM_OK: begin
                if (dedicated_charger_cycle) begin
                    next_handshake_outcome_status[`PPS_HS_CUSTOM] = 1'b1;
                    next_handshake_outcome_status[`PPS_HS_NONEG] = 1'b0;
                end
            end
            PPS_HS_DCP_OK: begin
                next_handshake_outcome_status[`PPS_HS_DCP] = 1'b1;
                next_handshake_outcome_status[`PPS_HS_NONEG] = 1'b0;
            end
            PPS_HS_CDP_OK: begin
                next_handshake_outcome_status[`PPS_HS_CDP] = 1'b1;
                next_handshake_outcome_status[`PPS_HS_NONEG] = 1'b0;
            end
            PPS_HS_PASSTHRU_OK: begin
                if (pt_armed) begin
                    next_handshake_outcome_status[`PPS_HS_PASSTHRU] = 1'b1;
                    next_handshake_outcome_status[`PPS_HS_NONEG] = 1'b0;
                    next_pt_armed = 1'b0;
                end
            end
            PPS_HS_NONE: begin
            end
            // Codes 6 and 7 name no outcome; dropped so stray values leave no flag
            default: begin
            end
        endcase
        next_handshake_outcome_status[`PPS_HS_UVLO] = supply_uvlo;
        next_handshake_outcome_status[6:5] = 2'b00;
    end

    ////////////////////////////////////////////////////////////////////
    // Host alert follows the fault flags, not the fault state bit: a latched
    // fault state whose causes were read away leaves the pin released
    always_comb begin
        thermal_irq = alert_link && charge_event_status[`PPS_CE_THERMAL];
        light_irq   = alert_link && charge_event_status[`PPS_CE_LIGHT];
        quota_irq   = (quota_action_sel == `PPS_QUOTA_ACT_IRQ)
                      && charge_event_status[`PPS_CE_QUOTA];
        next_host_alert_n = !((|fault_event_status[2:0]) || thermal_irq
                              || light_irq || quota_irq);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            host_alert_n <= 1'h1;
        end else begin
            host_alert_n <= next_host_alert_n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Attach pin; attach wins when both events land in one cycle
    always_comb begin
        next_plug_detect_n = plug_detect_n;
        if (attach_event) begin
            next_plug_detect_n = 1'h0;
        end else if (removal_event) begin
            next_plug_detect_n = 1'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            plug_detect_n <= 1'h1;
        end else begin
            plug_detect_n <= next_plug_detect_n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Port switch follows enable, undervoltage and fault state; data path follows the accepted profile
    always_comb begin
        next_power_switch_on = port_power_enable && !supply_uvlo
                               && !fault_event_status[`PPS_FE_FAULT_STATE];
        next_data_switch_closed = data_switch_closed;
        next_const_current_mode = const_current_mode;
        if (handshake_outcome_status[`PPS_HS_CUSTOM]) begin
            next_data_switch_closed = custom_dataswitch_close;
            next_const_current_mode = custom_const_current;
        end else if (handshake_outcome_status[`PPS_HS_DCP]) begin
            next_data_switch_closed = dedicated_mode_dataswitch_ctrl;
            next_const_current_mode = 1'h1;
        end else if (|handshake_outcome_status[1:0]) begin
            next_data_switch_closed = 1'h1;
            next_const_current_mode = 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            power_switch_on    <= 1'h0;
            data_switch_closed <= 1'h0;
            const_current_mode <= 1'h0;
        end else begin
            power_switch_on    <= next_power_switch_on;
            data_switch_closed <= next_data_switch_closed;
            const_current_mode <= next_const_current_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data captured at the read edge, before the clear lands
    always_comb begin
        next_reg_rdata = reg_rdata;
        if (reg_rd) begin
            if (hit(reg_addr, `PPS_ADDR_FAULT)) next_reg_rdata = fault_event_status;
            else if (hit(reg_addr, `PPS_ADDR_CHARGE)) next_reg_rdata = charge_event_status;
            else if (hit(reg_addr, `PPS_ADDR_HANDSHAKE)) next_reg_rdata = handshake_outcome_status;
            else next_reg_rdata = `PPS_RESET_VALUE;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= `PPS_RESET_VALUE;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status state, fed by the next-state process above
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fault_event_status <= `PPS_RESET_VALUE;
            port_power_enable_q           <= 1'h0;
        end else begin
            fault_event_status <= next_fault_event_status;
            port_power_enable_q           <= next_port_power_enable_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            charge_event_status <= `PPS_RESET_VALUE;
        end else begin
            charge_event_status <= next_charge_event_status;
        end
    end

    // Armed after reset, so the first pass-through outcome always shows
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            handshake_outcome_status <= `PPS_RESET_VALUE;
            pt_armed                 <= 1'h1;
            mode_line_q              <= 1'h0;
        end else begin
            handshake_outcome_status <= next_handshake_outcome_status;
            pt_armed                 <= next_pt_armed;
            mode_line_q              <= next_mode_line_q;
        end
    end
endmodule

// ===== core/pps_params.svh
// Register offsets, bit positions and reset values of the port status flags
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH

`define PPS_ADDR_FAULT     8'h10
`define PPS_ADDR_CHARGE    8'h11
`define PPS_ADDR_HANDSHAKE 8'h12
`define PPS_RESET_VALUE    8'h00

`define PPS_FE_FAULT_STATE 7
`define PPS_FE_OVERVOLT    2
`define PPS_FE_BACKV       1
`define PPS_FE_OVERCUR     0

`define PPS_CE_QUOTA       7
`define PPS_CE_REGION2     4
`define PPS_CE_THERMAL     3
`define PPS_CE_LIGHT       2
`define PPS_CE_UNPLUG      1
`define PPS_CE_CONNECT     0

`define PPS_HS_NONEG       7
`define PPS_HS_UVLO        4
`define PPS_HS_CUSTOM      3
`define PPS_HS_DCP         2
`define PPS_HS_CDP         1
`define PPS_HS_PASSTHRU    0

`define PPS_QUOTA_ACT_IRQ  2'h1

`endif

// ===== core/pps_pkg.sv
// Types shared by the port power status flag logic
package pps_pkg;
    typedef logic [7:0] pps_byte_t;
    typedef logic [1:0] pps_action_t;
    // Handshake outcome reported by the emulation engine
    typedef enum logic [2:0] {
        PPS_HS_NONE,
        PPS_HS_NOHANDSHAKE,
        PPS_HS_CUSTOM_OK,
        PPS_HS_DCP_OK,
        PPS_HS_CDP_OK,
        PPS_HS_PASSTHRU_OK
    } pps_hs_e;
endpackage

// ===== tb/pps_status_flags_properties.sv
// Port-level properties of the port power status flags
module pps_status_flags_chk (
    input wire logic               clk,
    input wire logic               reset_n,
    input wire logic               reg_rd,
    input wire pps_pkg::pps_byte_t reg_addr,
    input wire logic [7:0]         reg_rdata,
    input wire logic               supply_overvoltage,
    input wire logic               bus_backvoltage,
    input wire logic               bus_over_limit,
    input wire logic               bus_over_r2min,
    input wire logic               supply_uvlo,
    input wire logic               attach_event,
    input wire logic               removal_event,
    input wire logic               host_alert_n,
    input wire logic               plug_detect_n,
    input wire logic               power_switch_on
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Alert lags the cause by two edges: flag first, then the pin register
    a_ovp_alert_low: assert property ($rose(supply_overvoltage) |-> ##2 !host_alert_n)
        else $error("alert not low after overvoltage");
    a_backv_alert_low: assert property ($rose(bus_backvoltage) |-> ##2 !host_alert_n)
        else $error("alert not low after back-voltage");
    a_ocp_alert_low: assert property (
        $rose(bus_over_limit && bus_over_r2min) |-> ##2 !host_alert_n)
        else $error("alert not low after overcurrent");
    // Pin register updates at the event edge, so a following event may move it again
    a_attach_pin_low: assert property (
        attach_event && !removal_event |=> !plug_detect_n)
        else $error("attach pin not asserted");
    a_removal_pin_high: assert property (
        removal_event && !attach_event |=> plug_detect_n)
        else $error("attach pin not released");
    a_uvlo_switch_off: assert property (supply_uvlo [*3] |-> !power_switch_on)
        else $error("switch on during undervoltage");
    a_unmapped_reads_zero: assert property (
        reg_rd && !(reg_addr inside {[8'h10:8'h12]}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
endmodule

bind pps_status_flags pps_status_flags_chk u_chk (
    .clk, .reset_n, .reg_rd, .reg_addr, .reg_rdata, .supply_overvoltage, .bus_backvoltage,
    .bus_over_limit, .bus_over_r2min, .supply_uvlo, .attach_event, .removal_event,
    .host_alert_n, .plug_detect_n, .power_switch_on
);

// ===== tb/pps_host_model.sv
// Host side of the register port: single-byte reads and writes
module pps_host_model (
    input  wire logic          clk,
    output logic               reg_rd,
    output logic               reg_wr,
    output pps_pkg::pps_byte_t reg_addr,
    output pps_pkg::pps_byte_t reg_wdata,
    input  wire logic [7:0]    reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    import pps_pkg::*;
    initial begin
        {reg_rd, reg_wr, reg_addr, reg_wdata} = '0;
    end
    // Strobe held across exactly one sampling edge; data taken after it
    task automatic acc(input logic w, input pps_byte_t a, input pps_byte_t wd,
                       output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = wd;
        reg_rd = !w;
        reg_wr = w;
        @(posedge clk);
        #1;
        {reg_rd, reg_wr} = 2'h0;
        d = reg_rdata;
        // Unqualified lines show a changed pattern, never the last value
        reg_addr = ~a;
        reg_wdata = ~wd;
    endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the port power status flags
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pps_pkg::*;
    logic clk = 0, reset_n = 0;
    logic supply_overvoltage = 0, bus_backvoltage = 0, bus_over_limit = 0, bus_over_r2min = 0;
    logic supply_uvlo = 0, thermal_reg_active = 0, light_load = 0, quota_reached = 0;
    logic attach_event = 0, removal_event = 0, new_profile_applied = 0, new_active_mode = 0;
    logic dedicated_charger_cycle = 0, mode_select_line_one = 0, port_power_enable = 1;
    logic alert_link = 0, quota_enable = 0, quota_restart = 0, dedicated_mode_dataswitch_ctrl = 0;
    pps_action_t quota_action_sel = 2'h0;
    pps_hs_e hs_result = PPS_HS_NONE;
    logic custom_dataswitch_close = 0, custom_const_current = 0;
    logic reg_rd, reg_wr, host_alert_n, plug_detect_n, power_switch_on;
    logic data_switch_closed, const_current_mode;
    pps_byte_t reg_addr, reg_wdata;
    logic [7:0] reg_rdata, dummy;
    int mismatches = 0, num_checks = 0;
    always #20 clk = ~clk;
    pps_status_flags u_pps_status_flags (
        .clk, .reset_n, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
        .supply_overvoltage, .bus_backvoltage, .bus_over_limit, .bus_over_r2min, .supply_uvlo,
        .thermal_reg_active, .light_load, .quota_reached, .attach_event, .removal_event,
        .hs_result, .dedicated_charger_cycle, .new_profile_applied, .new_active_mode,
        .mode_select_line_one, .custom_dataswitch_close, .custom_const_current,
        .port_power_enable, .auto_recovery(1'h0), .alert_link, .quota_enable, .quota_restart,
        .quota_action_sel, .dedicated_mode_dataswitch_ctrl, .host_alert_n, .plug_detect_n,
        .power_switch_on, .data_switch_closed, .const_current_mode
    );
    pps_host_model u_pps_host_model (.clk, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (mismatches == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        cyc(1);
        s = 1'h0;
    endtask
    // Enable low across one sampling edge, so the disable is seen
    task automatic pwr_cycle();
        port_power_enable = 1'h0;
        cyc(1);
        port_power_enable = 1'h1;
    endtask
    task automatic hs(input pps_hs_e v);
        hs_result = v;
        cyc(1);
        hs_result = PPS_HS_NONE;
    endtask
    task automatic rdchk(input pps_byte_t a, input logic [7:0] e);
        logic [7:0] d;
        u_pps_host_model.acc(1'h0, a, 8'h00, d);
        `CHK($sformatf("reg %h", a), e, d)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK("alert_n", 1'h1, host_alert_n)
        `CHK("plug_n", 1'h1, plug_detect_n)
        for (int a = 8'h0f; a < 8'h14; a++) rdchk(pps_byte_t'(a), 8'h00);
    endtask
    task automatic t_fault_ov();
        supply_overvoltage = 1'h1;
        cyc(3);
        `CHK("alert_n", 1'h0, host_alert_n)
        rdchk(8'h10, 8'h84);
        rdchk(8'h10, 8'h84);
        u_pps_host_model.acc(1'h1, 8'h10, 8'h00, dummy);
        rdchk(8'h10, 8'h84);
        supply_overvoltage = 1'h0;
        cyc(1);
        rdchk(8'h10, 8'h84);
        rdchk(8'h10, 8'h80);
        `CHK("alert_n", 1'h1, host_alert_n)
        u_pps_host_model.acc(1'h1, 8'h10, 8'h00, dummy);
        rdchk(8'h10, 8'h00);
    endtask
    task automatic t_fault_other();
        for (int k = 0; k < 2; k++) begin
            bus_backvoltage = (k == 0);
            bus_over_limit = (k == 1);
            bus_over_r2min = (k == 1);
            cyc(3);
            `CHK("alert_n", 1'h0, host_alert_n)
            rdchk(8'h10, k == 0 ? 8'h82 : 8'h81);
            {bus_backvoltage, bus_over_limit, bus_over_r2min} = 3'h0;
            cyc(1);
            // Power disable is the second way out of the fault state
            if (k == 0) u_pps_host_model.acc(1'h1, 8'h10, 8'h00, dummy);
            else pwr_cycle();
            rdchk(8'h10, 8'h00);
        end
        bus_over_limit = 1'h1;
        cyc(2);
        rdchk(8'h11, 8'h10);
        rdchk(8'h10, 8'h00);
        bus_over_limit = 1'h0;
        cyc(2);
        rdchk(8'h11, 8'h00);
    endtask
    task automatic t_charge();
        pulse(attach_event);
        cyc(2);
        `CHK("plug_n", 1'h0, plug_detect_n)
        `CHK("alert_n", 1'h1, host_alert_n)
        rdchk(8'h11, 8'h01);
        rdchk(8'h11, 8'h00);
        pulse(removal_event);
        cyc(2);
        `CHK("plug_n", 1'h1, plug_detect_n)
        rdchk(8'h11, 8'h02);
        pulse(light_load);
        cyc(2);
        `CHK("alert_n", 1'h1, host_alert_n)
        rdchk(8'h11, 8'h04);
        alert_link = 1'h1;
        pulse(thermal_reg_active);
        cyc(2);
        `CHK("alert_n", 1'h0, host_alert_n)
        rdchk(8'h11, 8'h08);
        alert_link = 1'h0;
        quota_enable = 1'h1;
        quota_action_sel = 2'h1;
        pulse(quota_reached);
        cyc(2);
        `CHK("alert_n", 1'h0, host_alert_n)
        rdchk(8'h11, 8'h80);
        pulse(quota_reached);
        pulse(quota_restart);
        rdchk(8'h11, 8'h00);
        pulse(quota_reached);
        quota_enable = 1'h0;
        cyc(1);
        rdchk(8'h11, 8'h00);
    endtask
    task automatic t_uvlo();
        supply_uvlo = 1'h1;
        cyc(3);
        `CHK("switch", 1'h0, power_switch_on)
        rdchk(8'h12, 8'h10);
        supply_uvlo = 1'h0;
        cyc(3);
        rdchk(8'h12, 8'h00);
        `CHK("switch", 1'h1, power_switch_on)
    endtask
    task automatic t_handshake();
        dedicated_mode_dataswitch_ctrl = 1'h1;
        hs(PPS_HS_DCP_OK);
        rdchk(8'h12, 8'h04);
        `CHK("dsw", 1'h1, data_switch_closed)
        `CHK("ccm", 1'h1, const_current_mode)
        `CHK("alert_n", 1'h1, host_alert_n)
        pulse(new_active_mode);
        rdchk(8'h12, 8'h00);
        hs(PPS_HS_NOHANDSHAKE);
        rdchk(8'h12, 8'h00);
        dedicated_charger_cycle = 1'h1;
        hs(PPS_HS_NOHANDSHAKE);
        rdchk(8'h12, 8'h80);
        pulse(new_profile_applied);
        rdchk(8'h12, 8'h00);
        hs(PPS_HS_CDP_OK);
        rdchk(8'h12, 8'h02);
        pwr_cycle();
        rdchk(8'h12, 8'h00);
        hs(PPS_HS_PASSTHRU_OK);
        pulse(removal_event);
        pulse(attach_event);
        hs(PPS_HS_PASSTHRU_OK);
        rdchk(8'h12, 8'h00);
        mode_select_line_one = 1'h1;
        cyc(1);
        hs(PPS_HS_PASSTHRU_OK);
        rdchk(8'h12, 8'h01);
        rdchk(8'h11, 8'h03);
        custom_const_current = 1'h1;
        hs(PPS_HS_CUSTOM_OK);
        rdchk(8'h12, 8'h09);
        `CHK("dsw", 1'h0, data_switch_closed)
        `CHK("ccm", 1'h1, const_current_mode)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim();
    end
    initial begin
        cyc(10);
        reset_n = 1'h1;
        t_reset();
        t_fault_ov();
        t_fault_other();
        t_charge();
        t_uvlo();
        t_handshake();
        end_sim();
    end
endmodule
